// File: gcrb_params.svh
`ifndef GCRB_PARAMS_SVH
`define GCRB_PARAMS_SVH

// ==========================================================
// global index map
`define GCRB_IDX_CFG_CTRL   8'h02
`define GCRB_IDX_LDN        8'h07
`define GCRB_IDX_CHIP_ID    8'h20
`define GCRB_IDX_CHIP_REV   8'h21
`define GCRB_IDX_PWR        8'h22
`define GCRB_IDX_APS        8'h23
`define GCRB_IDX_CLK        8'h24
`define GCRB_IDX_ADDR_LO    8'h26
`define GCRB_IDX_ADDR_HI    8'h27
`define GCRB_IDX_ACTIVATE   8'h30

// ==========================================================
// field layouts, writable masks and reset values
`define GCRB_ZERO_BYTE      8'h00
`define GCRB_CFG_CTRL_MASK  8'h01
`define GCRB_SOFT_BIT       0
`define GCRB_PWR_MASK       8'h7d
`define GCRB_PWR_STBY_BIT   5
`define GCRB_PWR_STBY_MASK  8'h20
`define GCRB_APS_MASK       8'h79
`define GCRB_CLK_MASK       8'h4e
`define GCRB_CLK_RST        8'h44
`define GCRB_PLL_OFF_BIT    1
`define GCRB_OSC_HI         3
`define GCRB_OSC_LO         2
`define GCRB_OSC_STOP       2'b11
`define GCRB_ADDR16_BIT     6
`define GCRB_ADDR_LO_MASK   8'hfe
`define GCRB_ADDR_LO_DEF0   8'h2e
`define GCRB_ADDR_LO_DEF1   8'h4e
`define GCRB_QUAL16_MASK    16'hfffe
`define GCRB_QUAL12_MASK    16'h0ffe
`define GCRB_ACT_BIT        0
`define GCRB_LDN_SLOTS      16
`define GCRB_LDN_LIMIT      8'h10
`define GCRB_LDN_SEL_HI     3
`define GCRB_LDN_SEL_LO     0
`define GCRB_CHIP_ID_VAL    8'ha5
`define GCRB_CHIP_REV_VAL   8'h01

`endif

// File: gcrb_pkg.sv
package gcrb_pkg;
	// ==========================================================
	// shared types
	typedef logic [7:0]  gcrb_byte_t;
	typedef logic [15:0] gcrb_addr_t;
endpackage

// File: gcrb_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// two-stage synchroniser for a slow pin level
module gcrb_sync2
	import gcrb_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic d_i,
	output var  logic q_o
);
	logic meta_reg;
	logic sync_reg;

	// no reset: the strap must be stable while reset is held
	always_ff @(posedge clk_i) begin
		meta_reg <= d_i;
		sync_reg <= meta_reg;
	end

	assign q_o = sync_reg;
endmodule

`default_nettype wire

// File: gcrb_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcrb_params.svh"

// ==========================================================
// index/data port pair: address match, index holding, strobes
module gcrb_port
	import gcrb_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cfg_mode_i,
	input  wire gcrb_addr_t io_addr_i,
	input  wire logic       io_wr_i,
	input  wire logic       io_rd_i,
	input  wire gcrb_byte_t io_wdata_i,
	input  wire gcrb_addr_t base_i,
	input  wire logic       addr16_i,
	output var  gcrb_byte_t index_o,
	output var  logic       idx_rd_o,
	output var  logic       data_wr_o,
	output var  logic       data_rd_o
);
	gcrb_byte_t index_reg;
	gcrb_byte_t index_next;
	logic       hit;
	logic       idx_wr;

	// qualified compare; a0 is dropped because it picks index or data
	function automatic logic port_match(input gcrb_addr_t a, input gcrb_addr_t b, input logic q16);
		gcrb_addr_t m;
		m = q16 ? `GCRB_QUAL16_MASK : `GCRB_QUAL12_MASK;
		return ((a ^ b) & m) == 16'h0000;
	endfunction

	// decode; nothing is honoured outside configuration mode
	assign hit        = cfg_mode_i & port_match(io_addr_i, base_i, addr16_i);
	assign idx_wr     = hit & io_wr_i & ~io_addr_i[0];
	assign idx_rd_o   = hit & io_rd_i & ~io_addr_i[0];
	assign data_wr_o  = hit & io_wr_i & io_addr_i[0];
	assign data_rd_o  = hit & io_rd_i & io_addr_i[0];
	assign index_next = idx_wr ? io_wdata_i : index_reg;

	// index holds all eight bits written by the host
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			index_reg <= `GCRB_ZERO_BYTE;
		end else begin
			index_reg <= index_next;
		end
	end

	assign index_o = index_reg;
endmodule

`default_nettype wire

// File: gcrb_global_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcrb_params.svh"

// ==========================================================
// chip-level configuration register bank
// Functional notes
// - full eight-bit index decode, globals at 0x00-0x30
// - unimplemented registers up to 0x30 ignore writes, read zero
// - index then data access, configuration mode only
// - soft-reset bit loads soft-reset values
// - soft-reset bit clears itself after write
// - device number selects upper index bank
// - activation touches only selected logical device
// - identification byte is fixed, read only
// - revision byte is fixed, read only
// - one power bit per unit, 1/7 reserved
// - serial two power bit: standby reset only
// - auto power-saving bits per unit, bits 1/2/7 zero
// - control and power-saving reset, not soft
// - clock register resets to 0x44, not soft
// - pll bit zero runs, one stops
// - oscillator code 11 stops osc and baud
// - bit six selects 16-bit address qualification
// - low address byte, strap default, bit0 zero
// - high address byte resets zero, hard/main
// - high byte write relocates the ports
module gcrb_global_config
	import gcrb_pkg::*;
#(
	parameter gcrb_byte_t CHIP_ID  = `GCRB_CHIP_ID_VAL,  // arbitrary value
	parameter gcrb_byte_t CHIP_REV = `GCRB_CHIP_REV_VAL  // arbitrary value
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       standby_power_on_reset_i,
	input  wire logic       hard_reset_i,
	input  wire logic       addr_strap_i,
	input  wire logic       cfg_mode_i,
	input  wire gcrb_addr_t io_addr_i,
	input  wire logic       io_wr_i,
	input  wire logic       io_rd_i,
	input  wire gcrb_byte_t io_wdata_i,
	input  wire gcrb_byte_t ldev_rdata_i,
	output var  gcrb_byte_t io_rdata_o,
	output var  logic       io_ack_o,
	output var  gcrb_byte_t logical_device_o,
	output var  logic [15:0] activate_o,
	output var  logic       ldev_wr_o,
	output var  gcrb_byte_t ldev_index_o,
	output var  gcrb_byte_t ldev_wdata_o,
	output var  gcrb_byte_t unit_power_o,
	output var  gcrb_byte_t auto_power_o,
	output var  logic       pll_off_o,
	output var  logic       osc_run_o,
	output var  logic       baud_clock_generator_en_o,
	output var  logic       addr16_qual_o,
	output var  gcrb_addr_t config_base_o
);
	// ==========================================================
	// state
	gcrb_byte_t  cfg_ctrl_reg,  cfg_ctrl_next;
	gcrb_byte_t  ldn_reg,       ldn_next;
	gcrb_byte_t  pwr_reg,       pwr_next;
	gcrb_byte_t  aps_reg,       aps_next;
	gcrb_byte_t  clk_reg,       clk_next;
	gcrb_byte_t  addr_lo_reg,   addr_lo_next;
	gcrb_addr_t  base_reg,      base_next;
	logic [15:0] act_reg,       act_next;
	logic        osc_reg;
	gcrb_byte_t  rdata_reg;
	logic        ack_reg;
	logic        ldev_wr_reg;
	gcrb_byte_t  ldev_idx_reg;
	gcrb_byte_t  ldev_wd_reg;

	gcrb_byte_t  index;
	gcrb_byte_t  rd_byte;
	gcrb_byte_t  pwr_low_next;
	gcrb_byte_t  addr_lo_def;
	logic        pwr_b5_next;
	logic        idx_rd, data_wr, data_rd;
	logic        strap_sync;
	logic        full_rst, addr_rst, soft_rst;
	logic        wr_ctrl, wr_ldn, wr_pwr, wr_aps, wr_clk, wr_lo, wr_hi, wr_act;
	logic        upper_idx, ldn_in_range;

	// ==========================================================
	// port and strap
	gcrb_port u_port (
		.clk_i      (clk_i),
		.rst_i      (addr_rst),
		.cfg_mode_i (cfg_mode_i),
		.io_addr_i  (io_addr_i),
		.io_wr_i    (io_wr_i),
		.io_rd_i    (io_rd_i),
		.io_wdata_i (io_wdata_i),
		.base_i     (base_reg),
		.addr16_i   (clk_reg[`GCRB_ADDR16_BIT]),
		.index_o    (index),
		.idx_rd_o   (idx_rd),
		.data_wr_o  (data_wr),
		.data_rd_o  (data_rd)
	);

	gcrb_sync2 u_strap (
		.clk_i (clk_i),
		.d_i   (addr_strap_i),
		.q_o   (strap_sync)
	);

	// ==========================================================
	// reset sources; all synchronous, taking effect on the next edge
	assign full_rst = rst_i | standby_power_on_reset_i | hard_reset_i;
	assign addr_rst = rst_i | hard_reset_i;
	assign soft_rst = cfg_ctrl_reg[`GCRB_SOFT_BIT];

	// write strobes; other indices up to 0x30 silently drop the write, higher ones go to the logical device
	assign wr_ctrl      = data_wr & (index == `GCRB_IDX_CFG_CTRL);
	assign wr_ldn       = data_wr & (index == `GCRB_IDX_LDN);
	assign wr_pwr       = data_wr & (index == `GCRB_IDX_PWR);
	assign wr_aps       = data_wr & (index == `GCRB_IDX_APS);
	assign wr_clk       = data_wr & (index == `GCRB_IDX_CLK);
	assign wr_lo        = data_wr & (index == `GCRB_IDX_ADDR_LO);
	assign wr_hi        = data_wr & (index == `GCRB_IDX_ADDR_HI);
	assign wr_act       = data_wr & (index == `GCRB_IDX_ACTIVATE);
	assign upper_idx    = index > `GCRB_IDX_ACTIVATE;
	assign ldn_in_range = ldn_reg < `GCRB_LDN_LIMIT;

	// ==========================================================
	// next values
	// trigger lives one cycle only, so it never needs a zero write
	assign cfg_ctrl_next = full_rst ? `GCRB_ZERO_BYTE :
		wr_ctrl ? (io_wdata_i & `GCRB_CFG_CTRL_MASK) : `GCRB_ZERO_BYTE;

	assign ldn_next = (full_rst | soft_rst) ? `GCRB_ZERO_BYTE :
		wr_ldn ? io_wdata_i : ldn_reg;

	// serial-two power bit survives main, hard and soft reset
	assign pwr_low_next = (full_rst | soft_rst) ? `GCRB_ZERO_BYTE :
		wr_pwr ? (io_wdata_i & `GCRB_PWR_MASK) : pwr_reg;
	assign pwr_b5_next = standby_power_on_reset_i ? 1'b0 :
		wr_pwr ? io_wdata_i[`GCRB_PWR_STBY_BIT] : pwr_reg[`GCRB_PWR_STBY_BIT];
	assign pwr_next = (pwr_low_next & ~`GCRB_PWR_STBY_MASK) | (pwr_b5_next ? `GCRB_PWR_STBY_MASK : `GCRB_ZERO_BYTE);

	assign aps_next = full_rst ? `GCRB_ZERO_BYTE :
		wr_aps ? (io_wdata_i & `GCRB_APS_MASK) : aps_reg;

	// reserved bits 5:4 are masked, so a careless write is harmless
	assign clk_next = full_rst ? `GCRB_CLK_RST :
		wr_clk ? (io_wdata_i & `GCRB_CLK_MASK) : clk_reg;

	// low byte is staged; ports move only when the high byte lands
	assign addr_lo_def  = strap_sync ? `GCRB_ADDR_LO_DEF1 : `GCRB_ADDR_LO_DEF0;
	assign addr_lo_next = addr_rst ? addr_lo_def :
		wr_lo ? (io_wdata_i & `GCRB_ADDR_LO_MASK) : addr_lo_reg;
	assign base_next = addr_rst ? {`GCRB_ZERO_BYTE, addr_lo_def} :
		wr_hi ? {io_wdata_i, addr_lo_reg} : base_reg;

	// activation slot picked by the low bits of the device number
	function automatic logic [3:0] act_slot(input gcrb_byte_t ldn);
		return ldn[`GCRB_LDN_SEL_HI:`GCRB_LDN_SEL_LO];
	endfunction

	// activation lands on the selected slot only
	always_comb begin
		act_next = act_reg;
		if (full_rst | soft_rst) begin
			act_next = '0;
		end else if (wr_act & ldn_in_range) begin
			act_next[act_slot(ldn_reg)] = io_wdata_i[`GCRB_ACT_BIT];
		end
	end

	// ==========================================================
	// read mux; unlisted and reserved indices up to 0x30 read zero, higher ones read the logical device
	always_comb begin
		rd_byte = `GCRB_ZERO_BYTE;
		if (idx_rd) begin
			rd_byte = index;
		end else if (data_rd) begin
			case (index)
				`GCRB_IDX_CFG_CTRL: rd_byte = `GCRB_ZERO_BYTE;
				`GCRB_IDX_LDN:      rd_byte = ldn_reg;
				`GCRB_IDX_CHIP_ID:  rd_byte = CHIP_ID;
				`GCRB_IDX_CHIP_REV: rd_byte = CHIP_REV;
				`GCRB_IDX_PWR:      rd_byte = pwr_reg;
				`GCRB_IDX_APS:      rd_byte = aps_reg;
				`GCRB_IDX_CLK:      rd_byte = clk_reg;
				`GCRB_IDX_ADDR_LO:  rd_byte = addr_lo_reg;
				`GCRB_IDX_ADDR_HI:  rd_byte = base_reg[15:8];
				`GCRB_IDX_ACTIVATE: rd_byte = {7'h00, ldn_in_range & act_reg[act_slot(ldn_reg)]};
				default:            rd_byte = upper_idx ? ldev_rdata_i : `GCRB_ZERO_BYTE;
			endcase
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk_i) begin
		cfg_ctrl_reg <= cfg_ctrl_next;
		ldn_reg      <= ldn_next;
		pwr_reg      <= pwr_next;
		aps_reg      <= aps_next;
		clk_reg      <= clk_next;
		addr_lo_reg  <= addr_lo_next;
		base_reg     <= base_next;
		act_reg      <= act_next;
	end

	// clock state flop; code 11 stops oscillator and baud clock together
	always_ff @(posedge clk_i) begin
		osc_reg <= clk_next[`GCRB_OSC_HI:`GCRB_OSC_LO] != `GCRB_OSC_STOP;
	end

	// answer and upper-bank forwarding, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg    <= `GCRB_ZERO_BYTE;
			ack_reg      <= 1'b0;
			ldev_wr_reg  <= 1'b0;
			ldev_idx_reg <= `GCRB_ZERO_BYTE;
			ldev_wd_reg  <= `GCRB_ZERO_BYTE;
		end else begin
			rdata_reg    <= rd_byte;
			ack_reg      <= idx_rd | data_rd;
			ldev_wr_reg  <= data_wr & upper_idx;
			ldev_idx_reg <= index;
			ldev_wd_reg  <= io_wdata_i;
		end
	end

	// ==========================================================
	// outputs
	assign io_rdata_o                = rdata_reg;
	assign io_ack_o                  = ack_reg;
	assign logical_device_o          = ldn_reg;
	assign activate_o                = act_reg;
	assign ldev_wr_o                 = ldev_wr_reg;
	assign ldev_index_o              = ldev_idx_reg;
	assign ldev_wdata_o              = ldev_wd_reg;
	assign unit_power_o              = pwr_reg;
	assign auto_power_o              = aps_reg;
	assign pll_off_o                 = clk_reg[`GCRB_PLL_OFF_BIT];
	assign osc_run_o                 = osc_reg;
	assign baud_clock_generator_en_o = osc_reg;
	assign addr16_qual_o             = clk_reg[`GCRB_ADDR16_BIT];
	assign config_base_o             = base_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_soft_self_clear: assert property (soft_rst |=> !soft_rst)
		else $error("soft reset trigger did not clear");
	chk_soft_loads: assert property (
		soft_rst && !full_rst |=> ldn_reg == 8'h00 && act_reg == 16'h0000 && pwr_reg[4] == 1'b0)
		else $error("soft reset did not load soft values");
	chk_soft_spares_clk: assert property (soft_rst && !full_rst |=> $stable(clk_reg) && $stable(aps_reg))
		else $error("soft reset disturbed clock or power-saving");
	chk_id_read: assert property (data_rd && index == `GCRB_IDX_CHIP_ID |=> io_rdata_o == CHIP_ID && io_ack_o)
		else $error("identification byte wrong");
	chk_reserved_zero: assert property (
		data_rd && index > `GCRB_IDX_ADDR_HI && index <= 8'h2f |=> io_rdata_o == 8'h00)
		else $error("reserved index read nonzero");
	chk_pwr_b5_kept: assert property (hard_reset_i && !standby_power_on_reset_i |=> $stable(pwr_reg[5]))
		else $error("power bit five changed by non-standby reset");
	chk_clk_reset: assert property (hard_reset_i |=> clk_reg == 8'h44 ##1 osc_run_o)
		else $error("clock control reset value wrong");
	chk_base_move: assert property (wr_hi && !addr_rst |=> base_reg == {$past(io_wdata_i), $past(addr_lo_reg)})
		else $error("high byte write did not relocate ports");
	chk_no_cfg_access: assert property (!cfg_mode_i && io_wr_i && !full_rst && !soft_rst |=> $stable(ldn_reg))
		else $error("write honoured outside configuration mode");
	chk_act_only_sel: assert property (
		wr_act && !full_rst && !soft_rst |=> (($past(act_reg) ^ act_reg) & ~(16'h0001 << $past(ldn_reg[3:0]))) == 16'h0000)
		else $error("activation touched another device");

	// read answers, register writes and upper-bank forwarding
	chk_ack_on_read: assert property (
		(idx_rd || data_rd) |=> io_ack_o)
		else $error("read strobe got no answer");
	chk_idle_quiet: assert property (
		!(idx_rd || data_rd) |=> !io_ack_o && io_rdata_o == `GCRB_ZERO_BYTE)
		else $error("answer or read data outside a read");
	chk_rev_read: assert property (
		data_rd && index == `GCRB_IDX_CHIP_REV |=> io_rdata_o == CHIP_REV)
		else $error("revision byte wrong");
	chk_ctrl_reads_zero: assert property (
		data_rd && index == `GCRB_IDX_CFG_CTRL |=> io_rdata_o == `GCRB_ZERO_BYTE)
		else $error("control register read nonzero");
	chk_pwr_write: assert property (
		wr_pwr && !full_rst && !soft_rst |=> pwr_reg == ($past(io_wdata_i) & `GCRB_PWR_MASK))
		else $error("power register write wrong");
	chk_aps_write: assert property (
		wr_aps && !full_rst |=> aps_reg == ($past(io_wdata_i) & `GCRB_APS_MASK))
		else $error("power-saving register write wrong");
	chk_osc_follows: assert property (
		osc_run_o == (clk_reg[`GCRB_OSC_HI:`GCRB_OSC_LO] != `GCRB_OSC_STOP) && baud_clock_generator_en_o == osc_run_o)
		else $error("oscillator state does not follow its code");
	chk_lo_even: assert property (
		(addr_lo_reg & ~`GCRB_ADDR_LO_MASK) == `GCRB_ZERO_BYTE)
		else $error("low address byte has bit zero set");
	chk_upper_fwd: assert property (
		data_wr && upper_idx |=> ldev_wr_o && ldev_index_o == $past(index) && ldev_wdata_o == $past(io_wdata_i))
		else $error("upper bank write not forwarded");

	cov_soft_reset: cover property (wr_ctrl && io_wdata_i[0] ##1 soft_rst ##1 !soft_rst);
	cov_relocate:   cover property (wr_lo ##[1:20] wr_hi);
	cov_osc_stop:   cover property (wr_clk && io_wdata_i[3:2] == 2'b11 ##2 !osc_run_o);
	cov_activate:   cover property (wr_ldn ##[1:10] wr_act && io_wdata_i[0]);
	cov_upper_wr:   cover property (data_wr && upper_idx ##1 ldev_wr_o);
endmodule

`default_nettype wire

// File: gcrb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// host side: index/data port cycles, one strobe cycle each
module gcrb_host_model
	import gcrb_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       ack_i,
	input  wire gcrb_byte_t rdata_i,
	output var  gcrb_addr_t io_addr_o,
	output var  logic       io_wr_o,
	output var  logic       io_rd_o,
	output var  gcrb_byte_t io_wdata_o
);
	gcrb_addr_t base;
	gcrb_byte_t lo;

	initial begin
		base = 16'h004e;
		lo = 8'h4e;
		io_addr_o = 16'hffb1;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 8'h00;
	end

	// released address and data lines carry the inverse so a stale value never passes; both strobes drop to zero
	task automatic cyc(input logic rd, input gcrb_addr_t a, input gcrb_byte_t d,
		output gcrb_byte_t q, output logic ack);
		@(posedge clk_i);
		io_addr_o <= a;
		io_wdata_o <= d;
		io_wr_o <= ~rd;
		io_rd_o <= rd;
		@(posedge clk_i);
		io_addr_o <= ~a;
		io_wdata_o <= ~d;
		io_wr_o <= 1'b0;
		io_rd_o <= 1'b0;
		#1;
		q = rdata_i;
		ack = ack_i;
	endtask

	// index first, then data port
	task automatic reg_wr(input gcrb_byte_t idx, input gcrb_byte_t d);
		gcrb_byte_t q;
		logic       k;
		if (idx == 8'h24) begin
			d = d & 8'hcf; // reserved clock bits written as zero
		end
		cyc(1'b0, base, idx, q, k);
		cyc(1'b0, base | 16'h0001, d, q, k);
		if (idx == 8'h26) begin
			lo = d & 8'hfe;
		end
		if (idx == 8'h27) begin
			base = {d, lo}; // low byte first, high byte moves the ports
		end
	endtask

	task automatic reg_rd(input gcrb_byte_t idx, output gcrb_byte_t q, output logic k);
		cyc(1'b0, base, idx, q, k);
		cyc(1'b1, base | 16'h0001, 8'h00, q, k);
	endtask
endmodule

`default_nettype wire

// File: global_config_register_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module global_config_register_bank_tb_top
	import gcrb_pkg::*;
;
	logic        clk_i, rst_i, sby, hard, strap, cfg, wr, rd, ack, pll, osc, a16;
	gcrb_addr_t  addr, base;
	gcrb_byte_t  wd, rdat, ldrd, ldn;
	logic [15:0] act;
	logic        lwr, baud;
	gcrb_byte_t  lidx, lwd, upw, aps;
	int          mismatches, n_checks;

	// ==========================================================
	// design and host
	gcrb_global_config dut (.clk_i(clk_i), .rst_i(rst_i), .standby_power_on_reset_i(sby),
		.hard_reset_i(hard), .addr_strap_i(strap), .cfg_mode_i(cfg), .io_addr_i(addr),
		.io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wd), .ldev_rdata_i(ldrd), .io_rdata_o(rdat),
		.io_ack_o(ack), .logical_device_o(ldn), .activate_o(act), .ldev_wr_o(lwr),
		.ldev_index_o(lidx), .ldev_wdata_o(lwd), .unit_power_o(upw), .auto_power_o(aps), .pll_off_o(pll),
		.osc_run_o(osc), .baud_clock_generator_en_o(baud), .addr16_qual_o(a16), .config_base_o(base));
	gcrb_host_model hm (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdat), .io_addr_o(addr),
		.io_wr_o(wr), .io_rd_o(rd), .io_wdata_o(wd));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ==========================================================
	// checking helpers
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rdchk(input gcrb_byte_t idx, input gcrb_byte_t e);
		gcrb_byte_t q;
		logic       k;
		hm.reg_rd(idx, q, k);
		chk("read ack", 16'h0001, {15'h0000, k});
		chk($sformatf("index %h", idx), {8'h00, e}, {8'h00, q});
	endtask

	task automatic pulse_hard();
		@(posedge clk_i);
		hard <= 1'b1;
		@(posedge clk_i);
		hard <= 1'b0;
		#1;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		gcrb_byte_t ix[9] = '{8'h02, 8'h07, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h20, 8'h21};
		gcrb_byte_t ex[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h4e, 8'h00, 8'ha5, 8'h01};
		#1; // registers update on the release edge itself
		chk("base", 16'h004e, base);
		for (int i = 0; i < 9; i++) begin
			rdchk(ix[i], ex[i]);
		end
		@(posedge clk_i);
		#1;
		chk("answer one cycle", 16'h0000, {7'h00, ack, rdat});
	endtask

	task automatic t_masks();
		gcrb_byte_t rz[5] = '{8'h00, 8'h01, 8'h25, 8'h28, 8'h20};
		gcrb_byte_t re[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha5};
		gcrb_byte_t q;
		logic       k;
		for (int i = 0; i < 5; i++) begin
			hm.reg_wr(rz[i], 8'hff);
			rdchk(rz[i], re[i]);
		end
		hm.reg_wr(8'h22, 8'hff);
		chk("power out", 16'h007d, {8'h00, upw});
		rdchk(8'h22, 8'h7d);
		hm.reg_wr(8'h23, 8'hff);
		chk("saving out", 16'h0079, {8'h00, aps});
		rdchk(8'h23, 8'h79);
		rdchk(8'ha2, 8'h3c);
		hm.reg_wr(8'h24, 8'hff);
		chk("clk out", 16'h0101, {7'h00, pll, 7'h00, a16});
		chk("osc run", 16'h0000, {7'h00, baud, 7'h00, osc});
		rdchk(8'h24, 8'h4e);
		hm.reg_wr(8'h24, 8'h08);
		chk("clk out2", 16'h0100, {7'h00, osc, 7'h00, a16 | pll});
		hm.cyc(1'b0, 16'h304e, 8'h20, q, k);
		hm.cyc(1'b1, 16'h304f, 8'h00, q, k);
		chk("alias12", 16'h01a5, {7'h00, k, q});
	endtask

	task automatic t_ldn();
		hm.reg_wr(8'h07, 8'h03);
		hm.reg_wr(8'h30, 8'h01);
		chk("activate", 16'h0008, act);
		hm.reg_wr(8'h07, 8'h05);
		chk("ldn", 16'h0005, {8'h00, ldn});
		rdchk(8'h30, 8'h00);
	endtask

	task automatic t_soft();
		gcrb_byte_t q;
		logic       k;
		hm.reg_wr(8'h02, 8'h01);
		rdchk(8'h02, 8'h00);
		chk("act soft", 16'h0000, act);
		rdchk(8'h07, 8'h00);
		rdchk(8'h22, 8'h20);
		rdchk(8'h23, 8'h79);
		rdchk(8'h24, 8'h08);
		@(posedge clk_i);
		sby <= 1'b1;
		@(posedge clk_i);
		sby <= 1'b0;
		rdchk(8'h22, 8'h00);
		rdchk(8'h24, 8'h44);
		hm.cyc(1'b1, 16'h304f, 8'h00, q, k);
		chk("alias16", 16'h0000, {7'h00, k, q});
	endtask

	task automatic t_mode();
		@(posedge clk_i);
		cfg <= 1'b0;
		hm.reg_wr(8'h07, 8'h09);
		@(posedge clk_i);
		cfg <= 1'b1;
		rdchk(8'h07, 8'h00);
	endtask

	task automatic t_reloc();
		hm.reg_wr(8'h26, 8'h51);
		chk("base lo only", 16'h004e, base);
		rdchk(8'h26, 8'h50);
		hm.reg_wr(8'h27, 8'h12);
		chk("base moved", 16'h1250, base);
		rdchk(8'h27, 8'h12);
		pulse_hard();
		hm.base = 16'h004e;
		chk("base hard", 16'h004e, base);
		rdchk(8'h27, 8'h00);
	endtask

	task automatic t_upper();
		hm.reg_wr(8'h45, 8'h9c);
		chk("upper fwd", 16'h0001, {15'h0000, lwr});
		chk("upper idx data", 16'h459c, {lidx, lwd});
		@(posedge clk_i);
		#1;
		chk("upper pulse", 16'h0000, {15'h0000, lwr});
	endtask

	// main reset mid-run with the strap low; power bit five must survive
	task automatic t_strap();
		hm.reg_wr(8'h22, 8'h20);
		@(posedge clk_i);
		strap <= 1'b0;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk("base strap0", 16'h002e, base);
		hm.base = 16'h002e;
		rdchk(8'h26, 8'h2e);
		rdchk(8'h22, 8'h20);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		rst_i = 1'b1;
		sby = 1'b1;
		hard = 1'b0;
		strap = 1'b1;
		cfg = 1'b1;
		ldrd = 8'h3c;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		sby <= 1'b0;
		t_reset();
		t_masks();
		t_ldn();
		t_soft();
		t_mode();
		t_reloc();
		t_upper();
		t_strap();
		final_report();
	end

	// whole run is a few hundred cycles; this is far beyond it
	initial begin
		#(50 * 5000);
		mismatches++;
		final_report();
	end
endmodule

`default_nettype wire
